//--- core/cgs_pkg.sv
// Package for the clock generator status, divider and auto-trim block.
// Holds register offsets, field positions, reset values, types and the mode table.
package cgs_pkg;

   // Register offsets on the plain register port
   localparam logic [3:0] CGS_OFF_CTRL1       = 4'h0;
   localparam logic [3:0] CGS_OFF_TRIM_SLOW   = 4'h2;
   localparam logic [3:0] CGS_OFF_TRIM_FAST   = 4'h3;
   localparam logic [3:0] CGS_OFF_MONITOR     = 4'h5;
   localparam logic [3:0] CGS_OFF_MODE_STAT   = 4'h6;
   localparam logic [3:0] CGS_OFF_SC          = 4'h8;
   localparam logic [3:0] CGS_OFF_TRIM_CMP_HI = 4'hA;
   localparam logic [3:0] CGS_OFF_TRIM_CMP_LO = 4'hB;
   localparam logic [3:0] CGS_OFF_IRQ_STAT    = 4'hC;
   localparam logic [3:0] CGS_OFF_IRQ_CLR     = 4'hD;
   localparam logic [3:0] CGS_OFF_IRQ_EN      = 4'hE;

   // Status and control field positions
   localparam int CGS_SC_TRIM_EN   = 7;
   localparam int CGS_SC_TRIM_SEL  = 6;
   localparam int CGS_SC_TRIM_FAIL = 5;
   localparam int CGS_SC_FLL_KEEP  = 4;
   localparam int CGS_SC_DIV_MSB   = 3;
   localparam int CGS_SC_DIV_LSB   = 1;
   localparam int CGS_SC_OSC_LOSS  = 0;

   // Control 1 and monitor field positions
   localparam int CGS_C1_MODE_MSB = 2;
   localparam int CGS_C1_FAST_EN  = 3;
   localparam int CGS_MON_EN      = 0;

   // Interrupt status bits
   localparam int CGS_IRQ_LOSS = 0;
   localparam int CGS_IRQ_FAIL = 1;
   localparam int CGS_IRQ_DONE = 2;

   // Reset values and the trim search start bit
   localparam logic [7:0] CGS_RST_TRIM = 8'h80;
   localparam logic [2:0] CGS_RST_DIV  = 3'h0;
   localparam logic [2:0] CGS_TRIM_MSB = 3'h7;

   // Operating modes
   typedef enum logic [2:0] {
      CGS_MODE_FEI  = 3'b000,
      CGS_MODE_FEE  = 3'b001,
      CGS_MODE_FBI  = 3'b010,
      CGS_MODE_FBE  = 3'b011,
      CGS_MODE_BLPI = 3'b100,
      CGS_MODE_BLPE = 3'b101,
      CGS_MODE_STOP = 3'b110
   } cgs_mode_t;

   // Trim engine states
   typedef enum logic [0:0] {
      CGS_TRIM_IDLE    = 1'b0,
      CGS_TRIM_MEASURE = 1'b1
   } cgs_trim_st_t;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cgs_bus_req_t;

   // Frequency measurement result from the trim counter
   typedef struct packed {
      logic        valid;
      logic [15:0] count;
   } cgs_meas_t;

   // Permitted mode moves, one bit per destination code
   function automatic logic cgs_mode_allowed(input cgs_mode_t from_m, input logic [2:0] to_m);
      logic [6:0] row;
      row = 7'h00;
      case (from_m)
         CGS_MODE_FEI:  row = 7'h0E;
         CGS_MODE_FEE:  row = 7'h0D;
         CGS_MODE_FBI:  row = 7'h1B;
         CGS_MODE_FBE:  row = 7'h27;
         CGS_MODE_BLPI: row = 7'h04;
         CGS_MODE_BLPE: row = 7'h08;
         default:       row = 7'h00;
      endcase
      return (to_m == 3'h7) ? 1'b0 : row[to_m];
   endfunction

   // FLL output stays valid and its reference is unchanged across the move
   function automatic logic cgs_fll_keepable(input cgs_mode_t a, input cgs_mode_t b);
      logic fll_a;
      logic fll_b;
      logic int_a;
      logic int_b;
      fll_a = a inside {CGS_MODE_FEI, CGS_MODE_FEE, CGS_MODE_FBI, CGS_MODE_FBE};
      fll_b = b inside {CGS_MODE_FEI, CGS_MODE_FEE, CGS_MODE_FBI, CGS_MODE_FBE};
      int_a = a inside {CGS_MODE_FEI, CGS_MODE_FBI};
      int_b = b inside {CGS_MODE_FEI, CGS_MODE_FBI};
      return fll_a && fll_b && (int_a == int_b);
   endfunction

endpackage

//--- core/cgs_fast_ref_div.sv
// Divider for the fast internal reference: one output tick per 2^code input ticks.
// Assumes tick_in is a one-cycle enable pulse synchronous to clk.
`timescale 1ns/1ns
module cgs_fast_ref_div
   import cgs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       tick_in,
   input  wire logic [2:0] div_code,
   output logic            tick_out
);

   typedef struct packed {
      logic [6:0] cnt;
      logic       tick;
   } cgs_div_st_t;

   cgs_div_st_t s_r;
   cgs_div_st_t s_nxt;
   logic [6:0]  mask;

   // Terminal count for the selected power of two
   assign mask = 7'((8'h01 << div_code) - 8'h01);

   // Count input ticks; the >= test recovers if the code shrinks mid-count
   always_comb begin
      s_nxt      = s_r;
      s_nxt.tick = 1'b0;
      if (tick_in) begin
         if (s_r.cnt >= mask) begin
            s_nxt.cnt  = 7'h00;
            s_nxt.tick = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt + 7'h01;
         end
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tick_out = s_r.tick;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_div_one;
      (div_code == 3'h0) && tick_in |=> tick_out;
   endproperty
   a_div_one: assert property (p_div_one) else $error("divide by one lost a tick");

   property p_div_cause;
      tick_out |-> $past(tick_in);
   endproperty
   a_div_cause: assert property (p_div_cause) else $error("divider tick without input");

endmodule // cgs_fast_ref_div

//--- core/cgs_core.sv
// Clock generator status/control, mode machine, loss flag and auto-trim engine.
// Assumes one 125 MHz clock, synchronous inputs and a register port with one-cycle reads.
`timescale 1ns/1ns
module cgs_core
   import cgs_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire cgs_bus_req_t bus_req,
   output logic [7:0]        rdata,
   input  wire logic         osc_loss_detect,
   input  wire logic         stop_req,
   input  wire cgs_meas_t    meas,
   input  wire logic         fast_ref_tick,
   output logic              fast_ref_div_tick,
   output logic              fast_ref_enable,
   output logic [2:0]        mode,
   output logic              fll_filter_reset,
   output logic [7:0]        trim_slow_value,
   output logic [7:0]        trim_fast_value,
   output logic              trim_busy,
   output logic              osc_loss_status,
   output logic              irq
);

   typedef struct packed {
      logic [7:0]   rdata;
      cgs_mode_t    mode;
      cgs_mode_t    saved;
      logic [2:0]   mode_req;
      logic         fast_en;
      logic [7:0]   trim_slow;
      logic [7:0]   trim_fast;
      logic         mon_en;
      logic         te;
      logic         ts;
      logic         tf;
      logic         fp;
      logic [2:0]   div;
      logic         ol;
      logic [7:0]   cmp_hi;
      logic [7:0]   cmp_lo;
      cgs_trim_st_t tst;
      logic [2:0]   bit_idx;
      logic         trim_tgt;
      logic [2:0]   istat;
      logic [2:0]   ien;
      logic         irq;
      logic         fll_rst;
   } cgs_core_st_t;

   cgs_core_st_t s_r;
   cgs_core_st_t s_nxt;
   logic         wr;
   logic [3:0]   addr;
   logic [7:0]   wdata;
   logic         stop_entry;
   logic         ctrl_write;
   logic         abort;
   logic [15:0]  target;
   logic [7:0]   trim_cur;
   logic [7:0]   trim_new;

   // One SAR step: drop the trial bit when too fast, then try the next bit
   function automatic logic [7:0] sar_step(input logic [7:0] v, input logic [2:0] idx,
                                           input logic drop);
      logic [7:0] r;
      r = drop ? (v & ~(8'h01 << idx)) : v;
      if (idx != 3'h0) begin
         r = r | (8'h01 << (idx - 3'h1));
      end
      return r;
   endfunction

   // Bus and event decode
   assign wr         = bus_req.wr;
   assign addr       = bus_req.addr;
   assign wdata      = bus_req.wdata;
   assign stop_entry = stop_req && (s_r.mode != CGS_MODE_STOP);
   assign ctrl_write = wr && (addr inside {CGS_OFF_CTRL1, CGS_OFF_TRIM_SLOW,
                                           CGS_OFF_TRIM_FAST, CGS_OFF_SC});
   assign abort      = s_r.te && (ctrl_write || stop_entry);
   assign target     = {s_r.cmp_hi, s_r.cmp_lo};
   assign trim_cur   = s_r.trim_tgt ? s_r.trim_fast : s_r.trim_slow;
   assign trim_new   = sar_step(trim_cur, s_r.bit_idx, meas.count > target);

   // Next-state logic: writes first, then hardware sets so a set beats a clear
   always_comb begin
      s_nxt         = s_r;
      s_nxt.rdata   = 8'h00;
      s_nxt.fll_rst = 1'b0;

      // Register writes
      if (wr) begin
         case (addr)
            CGS_OFF_CTRL1: begin
               s_nxt.mode_req = wdata[CGS_C1_MODE_MSB:0];
               s_nxt.fast_en  = wdata[CGS_C1_FAST_EN];
            end
            CGS_OFF_TRIM_SLOW:   s_nxt.trim_slow = wdata;
            CGS_OFF_TRIM_FAST:   s_nxt.trim_fast = wdata;
            CGS_OFF_MONITOR:     s_nxt.mon_en    = wdata[CGS_MON_EN];
            CGS_OFF_TRIM_CMP_HI: s_nxt.cmp_hi    = wdata;
            CGS_OFF_TRIM_CMP_LO: s_nxt.cmp_lo    = wdata;
            CGS_OFF_IRQ_CLR:     s_nxt.istat     = s_r.istat & ~wdata[2:0];
            CGS_OFF_IRQ_EN:      s_nxt.ien       = wdata[2:0];
            CGS_OFF_SC: begin
               s_nxt.ts  = wdata[CGS_SC_TRIM_SEL];
               s_nxt.fp  = wdata[CGS_SC_FLL_KEEP];
               s_nxt.div = wdata[CGS_SC_DIV_MSB:CGS_SC_DIV_LSB];
               if (wdata[CGS_SC_TRIM_FAIL]) begin
                  s_nxt.tf = 1'b0;
               end
               if (wdata[CGS_SC_OSC_LOSS] && s_r.ol) begin
                  s_nxt.ol = 1'b0;
               end
               if (wdata[CGS_SC_TRIM_EN] && !s_r.te && !stop_req) begin
                  // Start the search at the top bit of the selected trim
                  s_nxt.te       = 1'b1;
                  s_nxt.tst      = CGS_TRIM_MEASURE;
                  s_nxt.bit_idx  = CGS_TRIM_MSB;
                  s_nxt.trim_tgt = wdata[CGS_SC_TRIM_SEL];
                  if (wdata[CGS_SC_TRIM_SEL]) begin
                     s_nxt.trim_fast = CGS_RST_TRIM;
                  end else begin
                     s_nxt.trim_slow = CGS_RST_TRIM;
                  end
               end
            end
            default: s_nxt.rdata = s_nxt.rdata;
         endcase
      end

      // Trim engine
      case (s_r.tst)
         CGS_TRIM_MEASURE: begin
            if (abort) begin
               s_nxt.te              = 1'b0;
               s_nxt.tst             = CGS_TRIM_IDLE;
               s_nxt.tf              = 1'b1;
               s_nxt.istat[CGS_IRQ_FAIL] = 1'b1;
            end else if (meas.valid) begin
               if (s_r.trim_tgt) begin
                  s_nxt.trim_fast = trim_new;
               end else begin
                  s_nxt.trim_slow = trim_new;
               end
               if (s_r.bit_idx == 3'h0) begin
                  s_nxt.te                  = 1'b0;
                  s_nxt.tst                 = CGS_TRIM_IDLE;
                  s_nxt.istat[CGS_IRQ_DONE] = 1'b1;
               end else begin
                  s_nxt.bit_idx = s_r.bit_idx - 3'h1;
               end
            end
         end
         CGS_TRIM_IDLE: s_nxt.tst = s_nxt.tst; // A start written above stands
         default:       s_nxt.tst = CGS_TRIM_IDLE;
      endcase

      // Oscillator loss, acted on only while the monitor is enabled
      if (osc_loss_detect && s_r.mon_en) begin
         s_nxt.ol                  = 1'b1;
         s_nxt.istat[CGS_IRQ_LOSS] = 1'b1;
      end

      // Mode machine with stop entry and exit
      if (stop_entry) begin
         s_nxt.mode  = CGS_MODE_STOP;
         s_nxt.saved = s_r.mode;
      end else if (s_r.mode == CGS_MODE_STOP) begin
         if (!stop_req) begin
            s_nxt.mode = s_r.saved;
         end
      end else if (s_r.mode_req != s_r.mode
                   && cgs_mode_allowed(s_r.mode, s_r.mode_req)) begin
         s_nxt.mode = cgs_mode_t'(s_r.mode_req);
      end

      // FLL filter reset on a mode change unless it may be preserved
      if (s_nxt.mode != s_r.mode) begin
         s_nxt.fll_rst = !(s_r.fp && cgs_fll_keepable(s_r.mode, s_nxt.mode));
      end

      // Interrupt follows the next status so it has no extra lag
      s_nxt.irq = |(s_nxt.istat & s_nxt.ien);

      // Read data for the following cycle
      if (bus_req.rd) begin
         case (addr)
            CGS_OFF_CTRL1:       s_nxt.rdata = {4'h0, s_r.fast_en, s_r.mode_req};
            CGS_OFF_TRIM_SLOW:   s_nxt.rdata = s_r.trim_slow;
            CGS_OFF_TRIM_FAST:   s_nxt.rdata = s_r.trim_fast;
            CGS_OFF_MONITOR:     s_nxt.rdata = {7'h00, s_r.mon_en};
            CGS_OFF_MODE_STAT:   s_nxt.rdata = {5'h00, s_r.mode};
            CGS_OFF_SC:          s_nxt.rdata = {s_r.te, s_r.ts, s_r.tf, s_r.fp,
                                                s_r.div, s_r.ol};
            CGS_OFF_TRIM_CMP_HI: s_nxt.rdata = s_r.cmp_hi;
            CGS_OFF_TRIM_CMP_LO: s_nxt.rdata = s_r.cmp_lo;
            CGS_OFF_IRQ_STAT:    s_nxt.rdata = {5'h00, s_r.istat};
            CGS_OFF_IRQ_EN:      s_nxt.rdata = {5'h00, s_r.ien};
            default:             s_nxt.rdata = 8'h00;
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r           <= '0;
         s_r.trim_slow <= CGS_RST_TRIM;
         s_r.trim_fast <= CGS_RST_TRIM;
         s_r.div       <= CGS_RST_DIV;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Fast reference divider, run only while the fast reference is enabled
   cgs_fast_ref_div u_div (
      .clk      (clk),
      .rst      (rst),
      .tick_in  (fast_ref_tick && s_r.fast_en),
      .div_code (s_r.div),
      .tick_out (fast_ref_div_tick)
   );

   // Outputs straight from state
   assign rdata            = s_r.rdata;
   assign fast_ref_enable  = s_r.fast_en;
   assign mode             = s_r.mode;
   assign fll_filter_reset = s_r.fll_rst;
   assign trim_slow_value  = s_r.trim_slow;
   assign trim_fast_value  = s_r.trim_fast;
   assign trim_busy        = s_r.te;
   assign osc_loss_status  = s_r.ol;
   assign irq              = s_r.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_loss_set;
      osc_loss_detect && s_r.mon_en |=> osc_loss_status;
   endproperty
   a_loss_set: assert property (p_loss_set) else $error("loss not flagged");

   property p_loss_ignored;
      !s_r.mon_en && !osc_loss_status |=> !osc_loss_status;
   endproperty
   a_loss_ignored: assert property (p_loss_ignored) else $error("loss flagged unmonitored");

   property p_loss_w1c;
      wr && addr == CGS_OFF_SC && wdata[0] && osc_loss_status
         && !(osc_loss_detect && s_r.mon_en) |=> !osc_loss_status;
   endproperty
   a_loss_w1c: assert property (p_loss_w1c) else $error("loss flag not cleared");

   property p_loss_w0;
      wr && addr == CGS_OFF_SC && !wdata[0] && osc_loss_status |=> osc_loss_status;
   endproperty
   a_loss_w0: assert property (p_loss_w0) else $error("loss flag lost on zero");

   property p_abort;
      trim_busy && wr && addr == CGS_OFF_CTRL1 |=> !trim_busy && s_r.tf && s_r.istat[1];
   endproperty
   a_abort: assert property (p_abort) else $error("trim not aborted");

   property p_fll_reset;
      (mode != $past(mode)) && !$past(s_r.fp) |-> fll_filter_reset;
   endproperty
   a_fll_reset: assert property (p_fll_reset) else $error("FLL not reset");

   property p_fll_keep;
      $past(s_r.fp) && $past(mode) == CGS_MODE_FEI && mode == CGS_MODE_FBI |-> !fll_filter_reset;
   endproperty
   a_fll_keep: assert property (p_fll_keep) else $error("FLL reset while preserved");

   property p_mode_legal;
      mode == CGS_MODE_FEI && !stop_req |=> !(mode inside {CGS_MODE_BLPI, CGS_MODE_BLPE});
   endproperty
   a_mode_legal: assert property (p_mode_legal) else $error("illegal mode move");

   property p_cmp_read;
      wr && addr == CGS_OFF_TRIM_CMP_HI ##1 bus_req.rd && addr == CGS_OFF_TRIM_CMP_HI
         |=> rdata == $past(wdata, 2);
   endproperty
   a_cmp_read: assert property (p_cmp_read) else $error("compare high readback wrong");

   property p_trim_start;
      wr && addr == CGS_OFF_SC && wdata[7] && !wdata[6] && !trim_busy && !stop_req
         |=> trim_busy && trim_slow_value == 8'h80;
   endproperty
   a_trim_start: assert property (p_trim_start) else $error("slow trim not started");

   property p_trim_end;
      s_r.tst == CGS_TRIM_MEASURE && !abort && meas.valid && s_r.bit_idx == 3'h0
         |=> !trim_busy && s_r.istat[2];
   endproperty
   a_trim_end: assert property (p_trim_end) else $error("trim did not finish");

   c_trim_done: cover property (s_r.tst == CGS_TRIM_MEASURE ##1 s_r.tst == CGS_TRIM_IDLE
                                && !s_r.tf);
   c_abort: cover property (abort);
   c_keep_move: cover property ((mode != $past(mode)) && !fll_filter_reset);
   c_irq: cover property (irq);

endmodule // cgs_core

//--- verif/testbench.sv
// Self-checking bench for the clock generator status, divider and trim block.
// Assumes cgs_core alone, driven through its plain register port at 125 MHz.
`timescale 1ns/1ns
module testbench
   import cgs_pkg::*;
;
   logic         clk;
   logic         rst;
   cgs_bus_req_t req;
   logic [7:0]   rdata;
   logic         loss;
   logic         stop_req;
   cgs_meas_t    meas_s;
   logic         tick;
   logic         div_tick;
   logic         fast_en;
   logic [2:0]   mode;
   logic         fll_rst;
   logic [7:0]   trim_slow;
   logic [7:0]   trim_fast;
   logic         trim_busy;
   logic         loss_st;
   logic         irq;
   int           error_cnt;
   int           n_tests;
   int           div_cnt;
   int           base;
   int           k;

   cgs_core uut (.clk(clk), .rst(rst), .bus_req(req), .rdata(rdata),
      .osc_loss_detect(loss), .stop_req(stop_req), .meas(meas_s),
      .fast_ref_tick(tick), .fast_ref_div_tick(div_tick), .fast_ref_enable(fast_en),
      .mode(mode), .fll_filter_reset(fll_rst), .trim_slow_value(trim_slow),
      .trim_fast_value(trim_fast), .trim_busy(trim_busy), .osc_loss_status(loss_st),
      .irq(irq));

   // Clock at 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Divided tick counter, cleared by reset
   always @(posedge clk) begin
      if (rst) begin
         div_cnt <= 0;
      end else if (div_tick === 1'b1) begin
         div_cnt <= div_cnt + 1;
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("Mismatches %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   // One-cycle read strobe, data sampled in the following cycle
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // Bounded wait for the trim engine to reach a level
   task automatic wait_busy(input logic lvl);
      int i;
      #1;
      for (i = 0; i < 6 && trim_busy !== lvl; i++) begin
         @(posedge clk);
         #1;
      end
      if (trim_busy !== lvl) begin
         error_cnt++;
         $display("[ERR] %0t trim engine wait ran out", $time);
         results();
      end
   endtask

   // One measurement pulse scaled from the current trial value
   task automatic pulse(input logic sel, input logic [15:0] scale);
      @(posedge clk);
      meas_s <= '{valid: 1'b1, count: (sel ? trim_fast : trim_slow) * scale};
      @(posedge clk);
      meas_s.valid <= 1'b0;
   endtask

   // Full trim run against a linear oscillator model
   task automatic trim(input logic sel, input logic [15:0] tgt, input logic [15:0] scale);
      logic [7:0] e;
      int         t;
      e = 8'h00;
      for (t = 0; t < 256; t++) if (t * scale <= tgt) e = t[7:0];
      wr(CGS_OFF_TRIM_CMP_HI, tgt[15:8]);
      wr(CGS_OFF_TRIM_CMP_LO, tgt[7:0]);
      wr(CGS_OFF_SC, {1'b1, sel, 6'h00});
      wait_busy(1'b1);
      chk(sel ? trim_fast : trim_slow, 16'h0080);
      for (t = 0; t < 8; t++) pulse(sel, scale);
      wait_busy(1'b0);
      chk(sel ? trim_fast : trim_slow, e);
      rdchk(CGS_OFF_IRQ_STAT, 8'h04);
      wr(CGS_OFF_IRQ_CLR, 8'h07);
   endtask

   // Abort by a control write or by stop entry
   task automatic abort(input logic by_stop);
      wr(CGS_OFF_SC, 8'h80);
      wait_busy(1'b1);
      pulse(1'b0, 16'h0010);
      wr(CGS_OFF_TRIM_CMP_HI, 8'h12);
      #1;
      chk(trim_busy, 1'b1);
      if (by_stop) begin
         @(posedge clk);
         stop_req <= 1'b1;
      end else begin
         wr(CGS_OFF_CTRL1, 8'h00);
      end
      repeat (2) @(posedge clk);
      #1;
      chk(trim_busy, 1'b0);
      rdchk(CGS_OFF_SC, 8'h20);
      rdchk(CGS_OFF_IRQ_STAT, 8'h02);
      @(posedge clk);
      stop_req <= 1'b0;
      wr(CGS_OFF_SC, 8'h20);
      wr(CGS_OFF_IRQ_CLR, 8'h07);
      rdchk(CGS_OFF_SC, 8'h00);
   endtask

   // Mode request, checking the filter reset pulse on the change
   task automatic move(input logic [2:0] m, input logic [2:0] em, input logic efr);
      logic seen;
      int   i;
      seen = 1'b0;
      wr(CGS_OFF_CTRL1, {5'h00, m});
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         if (fll_rst === 1'b1) seen = 1'b1;
      end
      chk(mode, em);
      chk(seen, efr);
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      req = '0;
      loss = 1'b0;
      stop_req = 1'b0;
      meas_s = '0;
      tick = 1'b0;
      error_cnt = 0;
      n_tests = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      // Reset values and compare bytes
      rdchk(CGS_OFF_SC, 8'h00);
      rdchk(CGS_OFF_TRIM_SLOW, 8'h80);
      chk(mode, 16'h0000);
      wr(CGS_OFF_TRIM_CMP_HI, 8'hA5);
      wr(CGS_OFF_TRIM_CMP_LO, 8'h3C);
      rdchk(CGS_OFF_TRIM_CMP_HI, 8'hA5);
      rdchk(CGS_OFF_TRIM_CMP_LO, 8'h3C);
      // Write then read back with no gap between the strobes
      @(posedge clk);
      req <= '{addr: CGS_OFF_TRIM_CMP_HI, wdata: 8'h5A, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '{addr: CGS_OFF_TRIM_CMP_HI, wdata: 8'h5A, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      chk(rdata, 8'h5A);
      rdchk(4'h1, 8'h00);
      // Divider codes, changed only while the fast reference is off
      for (k = 0; k < 8; k++) begin
         wr(CGS_OFF_SC, {4'h0, k[2:0], 1'b0});
         wr(CGS_OFF_CTRL1, 8'h08);
         base = div_cnt;
         @(posedge clk);
         tick <= 1'b1;
         repeat (256) @(posedge clk);
         tick <= 1'b0;
         repeat (3) @(posedge clk);
         chk(16'(div_cnt - base), 16'(256 >> k));
         wr(CGS_OFF_CTRL1, 8'h00);
      end
      wr(CGS_OFF_SC, 8'h00);
      // Loss flag with monitor off, then on
      @(posedge clk);
      loss <= 1'b1;
      @(posedge clk);
      loss <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(loss_st, 1'b0);
      wr(CGS_OFF_MONITOR, 8'h01);
      @(posedge clk);
      loss <= 1'b1;
      @(posedge clk);
      loss <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk(loss_st, 1'b1);
      chk(irq, 1'b0);
      wr(CGS_OFF_IRQ_EN, 8'h07);
      @(posedge clk);
      #1;
      chk(irq, 1'b1);
      wr(CGS_OFF_SC, 8'h00);
      rdchk(CGS_OFF_SC, 8'h01);
      wr(CGS_OFF_SC, 8'h01);
      rdchk(CGS_OFF_SC, 8'h00);
      rdchk(CGS_OFF_IRQ_STAT, 8'h01);
      wr(CGS_OFF_IRQ_CLR, 8'h01);
      @(posedge clk);
      #1;
      chk(irq, 1'b0);
      // Trim runs, both references, then aborts
      trim(1'b0, 16'h1234, 16'h0020);
      trim(1'b1, 16'h0A50, 16'h0010);
      chk(trim_slow, 16'h0091);
      abort(1'b0);
      abort(1'b1);
      // Mode moves with and without filter preserve
      move(3'd2, 3'd2, 1'b1);
      wr(CGS_OFF_SC, 8'h10);
      move(3'd0, 3'd0, 1'b0);
      move(3'd4, 3'd0, 1'b0);
      move(3'd2, 3'd2, 1'b0);
      move(3'd1, 3'd1, 1'b1);
      move(3'd3, 3'd3, 1'b0);
      move(3'd5, 3'd5, 1'b1);
      move(3'd0, 3'd5, 1'b0);
      move(3'd3, 3'd3, 1'b1);
      wr(CGS_OFF_SC, 8'h00);
      move(3'd1, 3'd1, 1'b1);
      move(3'd5, 3'd1, 1'b0);
      wr(CGS_OFF_CTRL1, 8'h09);
      repeat (2) @(posedge clk);
      #1;
      chk(fast_en, 1'b1);
      rdchk(CGS_OFF_MODE_STAT, 8'h01);
      @(posedge clk);
      stop_req <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(mode, 16'h0006);
      @(posedge clk);
      stop_req <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(mode, 16'h0001);
      results();
   end
endmodule // testbench
